// ==== bcw_exec.sv ====
// Execution of the memory bit clear and the three watchdog clear instructions.
`timescale 1ns/1ps
`include "bcw_regs.svh"

module bcw_exec #(
	parameter int DATA_WIDTH = `BCW_DATA_WIDTH,
	parameter int ADDR_WIDTH = `BCW_ADDR_WIDTH,
	parameter int SEL_WIDTH = $clog2(`BCW_DATA_WIDTH)
) (
	input wire logic clk_in, // Instruction clock, 20 MHz
	input wire logic rst_in, // Asynchronous reset, active high
	input wire logic instr_valid_in, // One-cycle strobe: an instruction is presented
	input wire logic [2:0] op_in, // Decoded operation code
	input wire logic [ADDR_WIDTH-1:0] mem_addr_in, // Address for the bit clear
	input wire logic [SEL_WIDTH-1:0] bit_sel_in, // Bit position for the bit clear
	input wire logic [DATA_WIDTH-1:0] mem_rdata_in, // Current content at mem_addr_in
	output logic mem_we_out, // One-cycle data memory write strobe
	output logic [ADDR_WIDTH-1:0] mem_addr_out, // Data memory write address
	output logic [DATA_WIDTH-1:0] mem_wdata_out, // Data memory write data
	output logic watchdog_counter_clear_out, // One-cycle pulse: reset watchdog_counter
	output logic watchdog_timeout_flag_clear_out, // One-cycle pulse: clear watchdog_timeout_flag
	output logic powerdown_flag_clear_out, // One-cycle pulse: clear powerdown_flag
	output logic pair_ignored_out, // One-cycle pulse: a pair half had no effect
	output logic illegal_op_out, // One-cycle pulse: unknown operation code
	output logic [2:0] pair_state_out // Which pair half ran last, one-hot
);

	// ****************************************************************
	// Parameter checks
	// ****************************************************************

	// A select narrower than the word would leave upper bits unreachable, so such a
	// configuration is refused while the design is built rather than misbehaving later.
	if (DATA_WIDTH < 2 || (1 << SEL_WIDTH) < DATA_WIDTH) begin
		$error("bcw_exec: bit select cannot reach every data bit");
	end
	if (ADDR_WIDTH < 1) begin
		$error("bcw_exec: address width must be at least one");
	end

	// ****************************************************************
	// Bit clear data path
	// ****************************************************************

	logic [DATA_WIDTH-1:0] cleared_word;

	// The read value arrives in the same cycle as the strobe, so the whole
	// read-modify-write completes in one instruction cycle.
	bcw_bit_clear #(
		.WIDTH(DATA_WIDTH),
		.SEL_WIDTH(SEL_WIDTH)
	) u_bit_clear (
		.data_in(mem_rdata_in),
		.sel_in(bit_sel_in),
		.data_out(cleared_word)
	);

	// ****************************************************************
	// Operation decode
	// ****************************************************************

	// Codes outside the known set raise a one-cycle report and do nothing else, so a
	// decoder fault can never clear the watchdog by accident.
	bcw_pkg::bcw_op_e op;
	logic op_known;

	always_comb begin
		op = bcw_pkg::bcw_op_e'(op_in);
		op_known = 1'b0;
		case (op_in)
			`BCW_OP_NONE,
			`BCW_OP_MEM_BIT_CLEAR,
			`BCW_OP_WDT_SINGLE,
			`BCW_OP_WDT_FIRST,
			`BCW_OP_WDT_SECOND: op_known = 1'b1;
			default: op_known = 1'b0;
		endcase
	end

	// ****************************************************************
	// Pair alternation record
	// ****************************************************************

	// The record is one-hot so that a corrupted value is seen as illegal and steered back
	// to neutral. Starting neutral means the first pair half after reset never clears the
	// watchdog: software must run one half before the other can take effect.
	bcw_pkg::bcw_pair_e pair_r;
	bcw_pkg::bcw_pair_e pair_nxt;
	logic pair_effect;
	logic pair_ignore;

	always_comb begin
		pair_nxt = pair_r;
		pair_effect = 1'b0;
		pair_ignore = 1'b0;
		if (instr_valid_in && op == bcw_pkg::BCW_OP_WDT_FIRST) begin
			unique case (pair_r)
				bcw_pkg::BCW_PAIR_SECOND: begin
					pair_effect = 1'b1;
					pair_nxt = bcw_pkg::BCW_PAIR_FIRST;
				end
				bcw_pkg::BCW_PAIR_NEUTRAL: begin
					// Nothing to alternate with yet; the half only arms the record.
					pair_ignore = 1'b1;
					pair_nxt = bcw_pkg::BCW_PAIR_FIRST;
				end
				bcw_pkg::BCW_PAIR_FIRST: begin
					pair_ignore = 1'b1;
				end
				default: begin
					pair_ignore = 1'b1;
					pair_nxt = bcw_pkg::BCW_PAIR_NEUTRAL;
				end
			endcase
		end else if (instr_valid_in && op == bcw_pkg::BCW_OP_WDT_SECOND) begin
			unique case (pair_r)
				bcw_pkg::BCW_PAIR_FIRST: begin
					pair_effect = 1'b1;
					pair_nxt = bcw_pkg::BCW_PAIR_SECOND;
				end
				bcw_pkg::BCW_PAIR_NEUTRAL: begin
					pair_ignore = 1'b1;
					pair_nxt = bcw_pkg::BCW_PAIR_SECOND;
				end
				bcw_pkg::BCW_PAIR_SECOND: begin
					pair_ignore = 1'b1;
				end
				default: begin
					pair_ignore = 1'b1;
					pair_nxt = bcw_pkg::BCW_PAIR_NEUTRAL;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pair_r <= bcw_pkg::BCW_PAIR_NEUTRAL;
		end else begin
			pair_r <= pair_nxt;
		end
	end

	// ****************************************************************
	// Output registers
	// ****************************************************************

	// Address and data hold their last value between writes; only the strobe marks a
	// valid write, which keeps the write port from toggling needlessly.
	logic mem_we_r;
	logic mem_we_nxt;
	logic [ADDR_WIDTH-1:0] mem_addr_r;
	logic [ADDR_WIDTH-1:0] mem_addr_nxt;
	logic [DATA_WIDTH-1:0] mem_wdata_r;
	logic [DATA_WIDTH-1:0] mem_wdata_nxt;
	logic wdt_clr_r;
	logic wdt_clr_nxt;
	logic ignored_r;
	logic ignored_nxt;
	logic illegal_r;
	logic illegal_nxt;

	always_comb begin
		mem_we_nxt = 1'b0;
		mem_addr_nxt = mem_addr_r;
		mem_wdata_nxt = mem_wdata_r;
		wdt_clr_nxt = 1'b0;
		ignored_nxt = pair_ignore;
		illegal_nxt = instr_valid_in && !op_known;
		if (instr_valid_in && op == bcw_pkg::BCW_OP_MEM_BIT_CLEAR) begin
			// No flag clear is raised here, so status flags stay as they are.
			mem_we_nxt = 1'b1;
			mem_addr_nxt = mem_addr_in;
			mem_wdata_nxt = cleared_word;
		end
		if (instr_valid_in && op == bcw_pkg::BCW_OP_WDT_SINGLE) begin
			wdt_clr_nxt = 1'b1;
		end
		if (pair_effect) begin
			wdt_clr_nxt = 1'b1;
		end
	end

	// Counter and both flags share one pulse, so they can never be cleared apart.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mem_we_r <= 1'b0;
			mem_addr_r <= '0;
			mem_wdata_r <= '0;
			wdt_clr_r <= 1'b0;
			ignored_r <= 1'b0;
			illegal_r <= 1'b0;
		end else begin
			mem_we_r <= mem_we_nxt;
			mem_addr_r <= mem_addr_nxt;
			mem_wdata_r <= mem_wdata_nxt;
			wdt_clr_r <= wdt_clr_nxt;
			ignored_r <= ignored_nxt;
			illegal_r <= illegal_nxt;
		end
	end

	// ****************************************************************
	// Output ports
	// ****************************************************************

	assign mem_we_out = mem_we_r;
	assign mem_addr_out = mem_addr_r;
	assign mem_wdata_out = mem_wdata_r;
	assign watchdog_counter_clear_out = wdt_clr_r;
	assign watchdog_timeout_flag_clear_out = wdt_clr_r;
	assign powerdown_flag_clear_out = wdt_clr_r;
	assign pair_ignored_out = ignored_r;
	assign illegal_op_out = illegal_r;
	assign pair_state_out = pair_r;

endmodule

// ==== bcw_regs.svh ====
// Constants for the bit clear and watchdog clear execution block.
`ifndef BCW_REGS_SVH
`define BCW_REGS_SVH

`define BCW_DATA_WIDTH 8
`define BCW_ADDR_WIDTH 8
`define BCW_BIT_CLEARED 1'b0
`define BCW_OP_NONE 3'h0
`define BCW_OP_MEM_BIT_CLEAR 3'h1
`define BCW_OP_WDT_SINGLE 3'h2
`define BCW_OP_WDT_FIRST 3'h3
`define BCW_OP_WDT_SECOND 3'h4
`define BCW_PAIR_NEUTRAL 3'h1
`define BCW_PAIR_FIRST 3'h2
`define BCW_PAIR_SECOND 3'h4

`endif

// ==== bcw_pkg.sv ====
// Types shared by the bit clear and watchdog clear execution block.
`include "bcw_regs.svh"

package bcw_pkg;

	typedef enum logic [2:0] {
		BCW_OP_NONE = `BCW_OP_NONE,
		BCW_OP_MEM_BIT_CLEAR = `BCW_OP_MEM_BIT_CLEAR,
		BCW_OP_WDT_SINGLE = `BCW_OP_WDT_SINGLE,
		BCW_OP_WDT_FIRST = `BCW_OP_WDT_FIRST,
		BCW_OP_WDT_SECOND = `BCW_OP_WDT_SECOND
	} bcw_op_e;

	typedef enum logic [2:0] {
		BCW_PAIR_NEUTRAL = `BCW_PAIR_NEUTRAL,
		BCW_PAIR_FIRST = `BCW_PAIR_FIRST,
		BCW_PAIR_SECOND = `BCW_PAIR_SECOND
	} bcw_pair_e;

endpackage

// ==== bcw_bit_clear.sv ====
// Combinational clearing of one selected bit within a data word.
`timescale 1ns/1ps

module bcw_bit_clear #(
	parameter int WIDTH = 8,
	parameter int SEL_WIDTH = 3
) (
	input wire logic [WIDTH-1:0] data_in, // Word as read from data memory
	input wire logic [SEL_WIDTH-1:0] sel_in, // Bit position to clear
	output logic [WIDTH-1:0] data_out // Word with that bit cleared
);

	if (WIDTH < 2 || (1 << SEL_WIDTH) < WIDTH) begin
		$error("bcw_bit_clear: bit select too narrow for the data width");
	end

	always_comb begin
		data_out = data_in;
		for (int i = 0; i < WIDTH; i++) begin
			if (sel_in == SEL_WIDTH'(i)) begin
				data_out[i] = `BCW_BIT_CLEARED;
			end
		end
	end

endmodule

// ==== bcw_exec_properties.sv ====
// Concurrent checks for the bit clear and watchdog clear execution block.
`timescale 1ns/1ps
module bcw_chk (
	input wire logic clk_in, // Clock
	input wire logic rst_in, // Reset
	input wire logic instr_valid_in, // Strobe
	input wire logic [2:0] op_in, // Operation
	input wire logic [7:0] mem_addr_in, // Address
	input wire logic [2:0] bit_sel_in, // Bit index
	input wire logic [7:0] mem_rdata_in, // Read data
	input wire logic mem_we_out, // Write strobe
	input wire logic [7:0] mem_addr_out, // Write address
	input wire logic [7:0] mem_wdata_out, // Write data
	input wire logic watchdog_counter_clear_out, // Counter clear
	input wire logic watchdog_timeout_flag_clear_out, // Time-out clear
	input wire logic powerdown_flag_clear_out, // Power-down clear
	input wire logic pair_ignored_out, // Ignored half
	input wire logic illegal_op_out, // Unknown code
	input wire logic [2:0] pair_state_out // Pair record
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	wire is_bit = instr_valid_in && op_in == 3'h1;
	wire is_one = instr_valid_in && op_in == 3'h2;
	wire is_fst = instr_valid_in && op_in == 3'h3;
	wire is_snd = instr_valid_in && op_in == 3'h4;
	sequence s_clr;
		watchdog_counter_clear_out && watchdog_timeout_flag_clear_out && powerdown_flag_clear_out;
	endsequence
	sequence s_ign;
		pair_ignored_out && !watchdog_counter_clear_out && !watchdog_timeout_flag_clear_out &&
			!powerdown_flag_clear_out;
	endsequence
	bit_clear_a: assert property (is_bit |=> mem_we_out && mem_addr_out == $past(mem_addr_in) &&
		mem_wdata_out == ($past(mem_rdata_in) & ~(8'h01 << $past(bit_sel_in)))) else $error("bit clear wrong");
	bit_quiet_a: assert property (is_bit |=> !watchdog_counter_clear_out && !powerdown_flag_clear_out &&
		!watchdog_timeout_flag_clear_out) else $error("bit clear touched flags");
	single_clear_a: assert property (is_one |=> s_clr) else $error("single clear missing");
	first_pair_a: assert property (is_fst && pair_state_out == 3'h4 |=> s_clr ##0 pair_state_out == 3'h2)
		else $error("first half not applied");
	first_repeat_a: assert property (is_fst && pair_state_out != 3'h4 |=> s_ign)
		else $error("first half not ignored");
	second_pair_a: assert property (is_snd && pair_state_out == 3'h2 |=> s_clr ##0 pair_state_out == 3'h4)
		else $error("second half not applied");
	second_repeat_a: assert property (is_snd && pair_state_out != 3'h2 |=> s_ign)
		else $error("second half not ignored");
	pair_hold_a: assert property (!(is_fst || is_snd) |=> $stable(pair_state_out))
		else $error("pair record moved");
endmodule

bind bcw_exec bcw_chk u_chk (.*);

// ==== bit_and_watchdog_clear_exec_tb_top.sv ====
// Self-checking testbench for the bit clear and watchdog clear execution block.
`timescale 1ns/1ps
module bit_and_watchdog_clear_exec_tb_top;
	logic clk_in = 1'b0, rst_in = 1'b1, instr_valid_in = 1'b0;
	logic [2:0] op_in = 3'h0, bit_sel_in = 3'h0, pair_state_out;
	logic [7:0] mem_addr_in = 8'h00, mem_rdata_in = 8'h00, mem_addr_out, mem_wdata_out;
	logic mem_we_out, watchdog_counter_clear_out, watchdog_timeout_flag_clear_out;
	logic powerdown_flag_clear_out, pair_ignored_out, illegal_op_out;
	int err_count = 0, compares = 0;
	// Pulses packed as write, counter, time-out, power-down, ignored, illegal.
	wire [7:0] pulses = {2'h0, mem_we_out, watchdog_counter_clear_out, watchdog_timeout_flag_clear_out,
		powerdown_flag_clear_out, pair_ignored_out, illegal_op_out};
	always #25 clk_in = ~clk_in;
	bcw_exec u_dut (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.instr_valid_in(instr_valid_in),
		.op_in(op_in),
		.mem_addr_in(mem_addr_in),
		.bit_sel_in(bit_sel_in),
		.mem_rdata_in(mem_rdata_in),
		.mem_we_out(mem_we_out),
		.mem_addr_out(mem_addr_out),
		.mem_wdata_out(mem_wdata_out),
		.watchdog_counter_clear_out(watchdog_counter_clear_out),
		.watchdog_timeout_flag_clear_out(watchdog_timeout_flag_clear_out),
		.powerdown_flag_clear_out(powerdown_flag_clear_out),
		.pair_ignored_out(pair_ignored_out),
		.illegal_op_out(illegal_op_out),
		.pair_state_out(pair_state_out)
	);
	// ****************************************
	// Drivers and comparison
	// ****************************************
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Valid stays high between back-to-back steps, so it is never written twice at one edge.
	task step(input logic [2:0] op, input logic [2:0] sel, input logic [7:0] rd, input logic [7:0] ep,
		input logic [2:0] es);
		instr_valid_in = 1'b1;
		op_in = op;
		bit_sel_in = sel;
		mem_rdata_in = rd;
		mem_addr_in = 8'h40 + {5'h00, sel};
		@(negedge clk_in);
		chk(pulses, ep);
		chk({5'h00, pair_state_out}, {5'h00, es});
	endtask
	task idle;
		instr_valid_in = 1'b0;
		@(negedge clk_in);
	endtask
	task complete_run;
		$display("Counts: %0d compares, %0d mismatches", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		chk(pulses, 8'h00);
		chk({5'h00, pair_state_out}, 8'h01);
		chk(mem_wdata_out, 8'h00);
		$display("Test reset done");
	endtask
	task t_bit;
		for (int i = 0; i < 8; i++) begin
			step(3'h1, i[2:0], 8'hA5 ^ i[7:0], 8'h20, 3'h1);
			chk(mem_wdata_out, (8'hA5 ^ i[7:0]) & ~(8'h01 << i));
			chk(mem_addr_out, 8'h40 + i[7:0]);
		end
		idle;
		$display("Test bit clear done");
	endtask
	task t_single;
		step(3'h2, 3'h0, 8'h00, 8'h1C, 3'h1);
		step(3'h2, 3'h0, 8'h00, 8'h1C, 3'h1);
		idle;
		$display("Test single clear done");
	endtask
	task t_pair;
		step(3'h3, 3'h0, 8'h00, 8'h02, 3'h2);
		step(3'h3, 3'h0, 8'h00, 8'h02, 3'h2);
		step(3'h4, 3'h0, 8'h00, 8'h1C, 3'h4);
		step(3'h4, 3'h0, 8'h00, 8'h02, 3'h4);
		step(3'h2, 3'h0, 8'h00, 8'h1C, 3'h4);
		step(3'h3, 3'h0, 8'h00, 8'h1C, 3'h2);
		step(3'h1, 3'h7, 8'hFF, 8'h20, 3'h2);
		chk(mem_wdata_out, 8'h7F);
		step(3'h4, 3'h0, 8'h00, 8'h1C, 3'h4);
		idle;
		$display("Test pair clear done");
	endtask
	task t_illegal;
		step(3'h0, 3'h0, 8'h00, 8'h00, 3'h4);
		for (int i = 5; i < 8; i++)
			step(i[2:0], 3'h0, 8'h00, 8'h01, 3'h4);
		idle;
		$display("Test illegal code done");
	endtask
	task t_midreset;
		rst_in = 1'b1;
		@(negedge clk_in);
		rst_in = 1'b0;
		chk({5'h00, pair_state_out}, 8'h01);
		chk(pulses, 8'h00);
		step(3'h4, 3'h0, 8'h00, 8'h02, 3'h4);
		idle;
		$display("Test second reset done");
	endtask
	initial begin
		repeat (4) @(negedge clk_in);
		rst_in = 1'b0;
		t_reset;
		t_bit;
		t_single;
		t_pair;
		t_illegal;
		t_midreset;
		complete_run;
	end
	// The tests take under 50 cycles; this limit leaves a wide margin.
	initial begin
		#20000;
		err_count++;
		complete_run;
	end
endmodule
